// ---- shared/fft_cfg.svh ----
// Constants of the FFT co-processor: field positions, codes and cycle counts.
`ifndef FFT_CFG_SVH
`define FFT_CFG_SVH

// ==========================================================================
// Configuration input fields
`define CFG_SIZE_LSB 0
`define CFG_REAL_BIT 2
`define CFG_INCFG_LSB 6
`define CFG_INCFG_DUAL 3'h5
`define CFG_INCFG_NONE 3'h0

// ==========================================================================
// Transform sizes in words
`define CFG_N_SMALL 11'h100
`define CFG_N_BIG 11'h400

// ==========================================================================
// Compute budgets in system clocks
`define CFG_P_C16X16 13'd420
`define CFG_P_C4X64 13'd624
`define CFG_P_C256 13'd816
`define CFG_P_C1024 13'd3907
`define CFG_P_R8X64 13'd816
`define CFG_P_R2X256 13'd1032
`define CFG_P_R2X1024 13'd4699
`define CFG_SYNC_MARGIN 13'd4

// ==========================================================================
// Output priming
`define CFG_PRIME_STROBES 3'd4

`endif

// ---- shared/fft_pkg.sv ----
// Types shared by the FFT co-processor modules.
package fft_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFORM = 2'b01,
        ST_DUMP = 2'b11
    } xf_state_t;

    typedef enum logic [1:0] {
        SZ_16X16 = 2'b00,
        SZ_4X64 = 2'b01,
        SZ_256 = 2'b10,
        SZ_1024 = 2'b11
    } xf_size_t;

endpackage

// ---- shared/ram_if.sv ----
// Port bundle between the controller and the sample memory.
`timescale 1ns/10ps
interface ram_if #(parameter int DW = 16, parameter int AW = 10);
    logic we_re;
    logic we_im;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata_re;
    logic [DW-1:0] wdata_im;
    logic [AW-1:0] raddr;
    logic [2*DW-1:0] rdata;
    modport ctrl (output we_re, output we_im, output waddr, output wdata_re, output wdata_im, output raddr,
        input rdata);
    modport ram (input we_re, input we_im, input waddr, input wdata_re, input wdata_im, input raddr,
        output rdata);
endinterface

// ---- testbench/fft_coprocessor_tb_top.sv ----
// Self-checking bench for the FFT co-processor in host controlled mode.
`timescale 1ns/10ps
module fft_coprocessor_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic input_strobe, output_strobe, write_enable_in, read_enable_in, definition_strobe;
    logic [15:0] aux_cfg, data_re_in, data_im_in, data_re_out, data_im_out;
    logic results_ready_flag, load_progress_flag, result_oe_n;
    logic [3:0] scale_out;
    int err_count = 0;
    int n_checks = 0;

    fft_coprocessor u_fft_coprocessor (.ref_clk(ref_clk), .rst_n(rst_n), .input_strobe(input_strobe),
        .output_strobe(output_strobe), .write_enable_in(write_enable_in), .read_enable_in(read_enable_in),
        .definition_strobe(definition_strobe), .aux_cfg(aux_cfg), .data_re_in(data_re_in),
        .data_im_in(data_im_in), .results_ready_flag(results_ready_flag),
        .load_progress_flag(load_progress_flag), .result_oe_n(result_oe_n), .data_re_out(data_re_out),
        .data_im_out(data_im_out), .scale_out(scale_out));
    host_model u_host_model (.ref_clk(ref_clk), .input_strobe(input_strobe), .output_strobe(output_strobe),
        .write_enable_in(write_enable_in), .read_enable_in(read_enable_in),
        .definition_strobe(definition_strobe), .aux_cfg(aux_cfg), .data_re_in(data_re_in),
        .data_im_in(data_im_in));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================================
    // Reporting
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================================
    // Load one block, wait for results and dump them all; mode 0 complex, 1 dual real, 2 single real
    // Loads never overlap a dump, so dump length cannot corrupt results.
    task automatic run_block(input string name, input logic [15:0] cfg, input int mode, input int n, input int p_lim,
        input logic [3:0] exp_scale);
        int k;
        logic [15:0] exp_re;
        u_host_model.define(cfg);
        for (k = 0; k < (mode == 2 ? 2 * n : n); k++) begin
            u_host_model.load(16'h0100 + 16'(k), 16'h0200 + 16'(k));
            if (k == 0) check("load flag while loading", 16'h0001, {15'h0000, load_progress_flag});
        end
        check("load flag after load", 16'h0000, {15'h0000, load_progress_flag});
        for (k = 0; k <= p_lim + 8 && results_ready_flag !== 1'b1; k++) @(posedge ref_clk);
        check("ready flag in budget", 16'h0001, {15'h0000, results_ready_flag});
        check("oe_n without read enable", 16'h0001, {15'h0000, result_oe_n});
        if (results_ready_flag !== 1'b1) results();
        check("scale tag", {12'h000, exp_scale}, {12'h000, scale_out});
        u_host_model.set_read(1'b1);
        repeat (4) @(posedge ref_clk);
        check("oe_n with read enable", 16'h0000, {15'h0000, result_oe_n});
        repeat (3) u_host_model.pulse(1'b0);
        for (k = 0; k < n; k++) begin
            u_host_model.pulse(1'b0);
            exp_re = (mode == 0 || k < n / 2) ? 16'h0100 + 16'(k) : 16'h0200 + 16'(k - n / 2);
            check("result re", exp_re, data_re_out);
            check("result im", mode != 0 ? 16'h0000 : 16'h0200 + 16'(k), data_im_out);
        end
        u_host_model.pulse(1'b0);
        check("ready flag after dump", 16'h0000, {15'h0000, results_ready_flag});
        check("oe_n after dump", 16'h0001, {15'h0000, result_oe_n});
        u_host_model.set_read(1'b0);
        @(posedge ref_clk);
        $display("test %s done", name);
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        check("oe_n after reset", 16'h0001, {15'h0000, result_oe_n});
        run_block("complex 256", 16'h0002, 0, 256, 816, 4'h5);
        run_block("dual real 256", 16'h0146, 1, 256, 1032, 4'h5);
        run_block("single real 256", 16'h0006, 2, 256, 1032, 4'h5);
        run_block("complex 1024", 16'h0003, 0, 1024, 3907, 4'h4);
        results();
    end
endmodule

// ---- testbench/host_model.sv ----
// Host side model that configures, loads and dumps the FFT co-processor.
`timescale 1ns/10ps
module host_model (
    input wire logic ref_clk,
    output logic input_strobe,
    output logic output_strobe,
    output logic write_enable_in,
    output logic read_enable_in,
    output logic definition_strobe,
    output logic [15:0] aux_cfg,
    output logic [15:0] data_re_in,
    output logic [15:0] data_im_in
);
    initial begin
        input_strobe = 1'b0;
        output_strobe = 1'b0;
        write_enable_in = 1'b0;
        read_enable_in = 1'b0;
        definition_strobe = 1'b0;
        aux_cfg = 16'h0000;
        data_re_in = 16'h0000;
        data_im_in = 16'h0000;
    end

    // Strobes stay high and low for six system clocks each.
    task automatic pulse(input logic is_load);
        @(posedge ref_clk);
        if (is_load) input_strobe <= 1'b1;
        else output_strobe <= 1'b1;
        repeat (6) @(posedge ref_clk);
        input_strobe <= 1'b0;
        output_strobe <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask

    // Mode set from a decode pulse, then four output strobes, ignored while read enable is low.
    task automatic define(input logic [15:0] cfg);
        @(posedge ref_clk);
        aux_cfg <= cfg;
        definition_strobe <= 1'b1;
        repeat (4) @(posedge ref_clk);
        definition_strobe <= 1'b0;
        aux_cfg <= ~cfg;
        repeat (4) pulse(1'b0);
    endtask

    task automatic set_read(input logic en);
        @(posedge ref_clk);
        read_enable_in <= en;
    endtask

    // One enabled write strobe per word; released data shows the inverse.
    task automatic load(input logic [15:0] re, input logic [15:0] im);
        @(posedge ref_clk);
        data_re_in <= re;
        data_im_in <= im;
        write_enable_in <= 1'b1;
        pulse(1'b1);
        data_re_in <= ~re;
        data_im_in <= ~im;
        write_enable_in <= 1'b0;
    endtask
endmodule

// ---- verilog/fft_coprocessor.sv ----
// Host controlled FFT co-processor: load, transform, prime and dump of result blocks.
// What this block does
// - A full loaded block starts the transform itself; ready flag marks results.
// - Dual real transforms share one block floating point shift from both blocks.
// - Eight by 64 real exists; sixteen by 16 has no real form.
// - Real blocks yield results for the first half of the bins only.
// - Single source plain real mode takes samples from real inputs only.
// - Input code 101 loads two independent sources on real and imaginary inputs.
// - Dual input results of the real lane precede those of the imaginary lane.
// - Overlap output gives each pair, then the pairs displaced by the step (one more at 50%, three more at 75%), except in 1024 modes (one pass only).
// - Eight by 64 dual real interleaves results as 1A 1B 2A 2B.
// - Complex transforms finish within 420, 624, 816 and 3907 clocks.
// - Real transforms finish within 816, 1032 and 4699 clocks.
// - In 1024 modes the load flag still marks the programmed overlap point.
// - In 1024 modes load, transform and dump run strictly in sequence.
// - Result outputs drive only with ready flag and read enable; the scale output is not gated by either.
`timescale 1ns/10ps
module fft_coprocessor
    import fft_pkg::*;
#(
    parameter int DW = 16,
    parameter int AW = 10
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic input_strobe,
    input wire logic output_strobe,
    input wire logic write_enable_in,
    input wire logic read_enable_in,
    input wire logic definition_strobe,
    input wire logic [15:0] aux_cfg,
    input wire logic [DW-1:0] data_re_in,
    input wire logic [DW-1:0] data_im_in,
    output logic results_ready_flag,
    output logic load_progress_flag,
    output logic result_oe_n,
    output logic [DW-1:0] data_re_out,
    output logic [DW-1:0] data_im_out,
    output logic [3:0] scale_out
);
`include "fft_cfg.svh"

    ram_if #(.DW(DW), .AW(AW)) ram ();
    sample_ram #(.DW(DW), .AW(AW)) u_ram (.ref_clk(ref_clk), .bus(ram.ram));

    // ==========================================================================
    // Input synchronisers
    logic [4:0] ctl1_r, ctl2_r, ctl3_r;
    logic [2*DW+15:0] dat1_r, dat2_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctl1_r <= 5'h00;
            ctl2_r <= 5'h00;
            ctl3_r <= 5'h00;
            dat1_r <= '0;
            dat2_r <= '0;
        end else begin
            ctl1_r <= {input_strobe, output_strobe, write_enable_in, read_enable_in, definition_strobe};
            ctl2_r <= ctl1_r;
            ctl3_r <= ctl2_r;
            dat1_r <= {aux_cfg, data_re_in, data_im_in};
            dat2_r <= dat1_r;
        end
    end
    logic is_rise, os_rise, wen_s, ren_s, def_s;
    logic [DW-1:0] din_re, din_im;
    logic [15:0] aux_s;
    assign is_rise = ctl2_r[4] & ~ctl3_r[4];
    assign os_rise = ctl2_r[3] & ~ctl3_r[3];
    assign wen_s = ctl2_r[2];
    assign ren_s = ctl2_r[1];
    assign def_s = ctl2_r[0];
    assign {aux_s, din_re, din_im} = dat2_r;

    // ==========================================================================
    // Mode decode
    xf_size_t size_r;
    logic real_r;
    logic [2:0] incfg_r;
    logic big, rmode, single_src, ovl50, ovl75;
    logic [15:0] n_w, sb_w, step_w, lim_j, subs, ld_total, ld_point;
    logic [12:0] p_lim;
    logic [2:0] passes;
    always_comb begin
        big = (size_r == SZ_1024);
        rmode = real_r && (size_r != SZ_16X16);
        // single source unless a dual or overlap code is set
        single_src = rmode && (incfg_r == `CFG_INCFG_NONE);
        ovl50 = rmode && (incfg_r == 3'h1 || incfg_r == 3'h2 || incfg_r == 3'h6);
        ovl75 = rmode && (incfg_r == 3'h3 || incfg_r == 3'h4 || incfg_r == 3'h7);
        n_w = big ? {5'h00, `CFG_N_BIG} : {5'h00, `CFG_N_SMALL};
        case (size_r)
            SZ_16X16: sb_w = 16'h0010;
            SZ_4X64: sb_w = 16'h0040;
            SZ_256: sb_w = 16'h0100;
            default: sb_w = 16'h0400;
        endcase
        // real blocks dump half the bins
        lim_j = rmode ? (sb_w >> 1) : sb_w;
        subs = n_w / sb_w;
        step_w = ovl50 ? (n_w >> 1) : (n_w >> 2);
        // passes per dump, displaced ones included; the external buffer does it in 1024 modes
        passes = (big || !(ovl50 || ovl75)) ? 3'd1 : (ovl50 ? 3'd2 : 3'd4);
        ld_total = single_src ? (n_w << 1) : n_w;
        // load flag falls at the overlap point in every size
        ld_point = ovl50 ? (ld_total >> 1) : (ovl75 ? (ld_total >> 2) : ld_total);
        case (size_r)
            SZ_16X16: p_lim = `CFG_P_C16X16;
            SZ_4X64: p_lim = rmode ? `CFG_P_R8X64 : `CFG_P_C4X64;
            SZ_256: p_lim = rmode ? `CFG_P_R2X256 : `CFG_P_C256;
            default: p_lim = rmode ? `CFG_P_R2X1024 : `CFG_P_C1024;
        endcase
    end

    function automatic logic [15:0] mag(input logic [15:0] x);
        return x[15] ? 16'(~x + 16'h0001) : x;
    endfunction
    function automatic logic [3:0] headroom(input logic [15:0] m);
        logic [3:0] h;
        h = 4'hf;
        for (int i = 0; i < 15; i++) begin
            if (m[i]) begin
                h = 4'(14 - i);
            end
        end
        if (m[15]) begin
            h = 4'h0;
        end
        return h;
    endfunction

    // ==========================================================================
    // Control state
    xf_state_t st_r, st_nxt;
    logic ld_act_r, ld_act_nxt, ld_pend_r, ld_pend_nxt, ld_done;
    logic [15:0] ld_cnt_r, ld_cnt_nxt;
    logic [12:0] xcnt_r, xcnt_nxt;
    logic [15:0] scan_r, scan_nxt, smax_r, smax_nxt;
    logic scan_v_r, scan_v_nxt, drd_v_r, drd_v_nxt, lane_r, lane_nxt;
    logic [3:0] shift_r, shift_nxt;
    logic [15:0] j_r, j_nxt, s_r, s_nxt;
    logic l_r, l_nxt;
    logic [2:0] p_r, p_nxt, prime_r, prime_nxt;
    logic dav_nxt, oe_n_nxt, load_progress_flag_nxt;
    logic [DW-1:0] dre_nxt, dim_nxt;
    logic [15:0] sum, dump_addr;
    logic accept, last, ev;

    always_comb begin
        st_nxt = st_r;
        ld_act_nxt = ld_act_r;
        ld_pend_nxt = ld_pend_r;
        ld_cnt_nxt = ld_cnt_r;
        xcnt_nxt = xcnt_r;
        scan_nxt = scan_r;
        smax_nxt = smax_r;
        scan_v_nxt = 1'b0;
        drd_v_nxt = 1'b0;
        lane_nxt = lane_r;
        shift_nxt = shift_r;
        j_nxt = j_r;
        s_nxt = s_r;
        l_nxt = l_r;
        p_nxt = p_r;
        prime_nxt = prime_r;
        dre_nxt = data_re_out;
        dim_nxt = data_im_out;
        ld_done = 1'b0;
        ram.we_re = 1'b0;
        ram.we_im = 1'b0;
        ram.waddr = AW'(ld_cnt_r & (n_w - 16'h0001));
        ram.wdata_re = din_re;
        ram.wdata_im = din_im;
        ram.raddr = AW'(scan_r);
        sum = 16'(p_r * step_w) + 16'(s_r * sb_w) + j_r;
        dump_addr = sum & (n_w - 16'h0001);
        // The final advance steps the pass count past the end; the strobe after that closes the dump.
        last = (p_r == passes);
        ev = os_rise && ren_s && (st_r == ST_DUMP);
        // a load starts only when no transform runs and nothing is pending and, in 1024 modes, only from idle
        accept = is_rise && wen_s && (ld_act_r || (st_r != ST_XFORM && !ld_pend_r && !(big && st_r != ST_IDLE)));
        if (accept) begin
            // single source fills the real lane, then the imaginary lane, from real inputs
            if (single_src) begin
                ram.we_re = (ld_cnt_r < n_w);
                ram.we_im = (ld_cnt_r >= n_w);
                ram.wdata_im = din_re;
            end else begin
                ram.we_re = 1'b1;
                ram.we_im = 1'b1;
            end
            ld_act_nxt = 1'b1;
            ld_cnt_nxt = ld_cnt_r + 16'h0001;
            if (ld_cnt_r == ld_total - 16'h0001) begin
                ld_act_nxt = 1'b0;
                ld_cnt_nxt = 16'h0000;
                ld_done = 1'b1;
            end
        end
        case (st_r)
            ST_IDLE: begin
                // start the transform with no host action
                if (ld_done || ld_pend_r) begin
                    st_nxt = ST_XFORM;
                    ld_pend_nxt = 1'b0;
                    xcnt_nxt = p_lim - `CFG_SYNC_MARGIN;
                    scan_nxt = 16'h0000;
                    smax_nxt = 16'h0000;
                end
            end
            ST_XFORM: begin
                if (scan_r < n_w) begin
                    scan_nxt = scan_r + 16'h0001;
                    scan_v_nxt = 1'b1;
                end
                // one shift from the peak of both lanes
                if (scan_v_r) begin
                    if (mag(ram.rdata[2*DW-1:DW]) > smax_nxt) begin
                        smax_nxt = mag(ram.rdata[2*DW-1:DW]);
                    end
                    if (mag(ram.rdata[DW-1:0]) > smax_nxt) begin
                        smax_nxt = mag(ram.rdata[DW-1:0]);
                    end
                end
                xcnt_nxt = xcnt_r - 13'd1;
                // finish inside the budget of the mode
                if (xcnt_r == 13'd0) begin
                    st_nxt = ST_DUMP;
                    shift_nxt = headroom(smax_r);
                    j_nxt = 16'h0000;
                    s_nxt = 16'h0000;
                    l_nxt = 1'b0;
                    p_nxt = 3'd0;
                    prime_nxt = 3'd1;
                end
            end
            ST_DUMP: begin
                ram.raddr = AW'(dump_addr);
                if (ev && prime_r < `CFG_PRIME_STROBES) begin
                    prime_nxt = prime_r + 3'd1;
                    drd_v_nxt = (prime_r == `CFG_PRIME_STROBES - 3'd1);
                    lane_nxt = l_r;
                end else if (ev && last) begin
                    st_nxt = ld_pend_r ? ST_XFORM : ST_IDLE;
                    ld_pend_nxt = 1'b0;
                    xcnt_nxt = p_lim - `CFG_SYNC_MARGIN;
                    scan_nxt = 16'h0000;
                    smax_nxt = 16'h0000;
                end else if (ev) begin
                    j_nxt = j_r + 16'h0001;
                    if (j_r == lim_j - 16'h0001) begin
                        j_nxt = 16'h0000;
                        // dual sources put lane A before lane B inside each sub-block
                        if (rmode && !single_src && !l_r) begin
                            l_nxt = 1'b1;
                        end else if (s_r != subs - 16'h0001) begin
                            s_nxt = s_r + 16'h0001;
                            l_nxt = single_src ? l_r : 1'b0;
                        end else if (single_src && !l_r) begin
                            s_nxt = 16'h0000;
                            l_nxt = 1'b1;
                        end else begin
                            // next pass is the overlap-displaced pair
                            s_nxt = 16'h0000;
                            l_nxt = 1'b0;
                            p_nxt = p_r + 3'd1;
                        end
                    end
                    drd_v_nxt = 1'b1;
                end
                if (drd_v_r) begin
                    dre_nxt = !rmode ? ram.rdata[2*DW-1:DW] : (lane_r ? ram.rdata[DW-1:0] : ram.rdata[2*DW-1:DW]);
                    dim_nxt = !rmode ? ram.rdata[DW-1:0] : '0;
                end
                if (ev) begin
                    lane_nxt = l_r;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        if (ld_done && st_r != ST_IDLE) begin
            ld_pend_nxt = 1'b1;
        end
        if (def_s) begin
            st_nxt = ST_IDLE;
            ld_act_nxt = 1'b0;
            ld_pend_nxt = 1'b0;
            ld_cnt_nxt = 16'h0000;
        end
        dav_nxt = (st_nxt == ST_DUMP);
        // drive only with ready flag and read enable
        oe_n_nxt = !(dav_nxt && ren_s);
        load_progress_flag_nxt = ld_act_nxt && (ld_cnt_nxt < ld_point);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            size_r <= SZ_16X16;
            real_r <= 1'b0;
            incfg_r <= 3'h0;
            ld_act_r <= 1'b0;
            ld_pend_r <= 1'b0;
            ld_cnt_r <= 16'h0000;
            xcnt_r <= 13'd0;
            scan_r <= 16'h0000;
            smax_r <= 16'h0000;
            scan_v_r <= 1'b0;
            drd_v_r <= 1'b0;
            lane_r <= 1'b0;
            shift_r <= 4'h0;
            j_r <= 16'h0000;
            s_r <= 16'h0000;
            l_r <= 1'b0;
            p_r <= 3'd0;
            prime_r <= 3'd0;
            results_ready_flag <= 1'b0;
            load_progress_flag <= 1'b0;
            result_oe_n <= 1'b1;
            data_re_out <= '0;
            data_im_out <= '0;
            scale_out <= 4'h0;
        end else begin
            if (def_s) begin
                size_r <= xf_size_t'(aux_s[`CFG_SIZE_LSB +: 2]);
                real_r <= aux_s[`CFG_REAL_BIT];
                incfg_r <= aux_s[`CFG_INCFG_LSB +: 3];
            end
            st_r <= st_nxt;
            ld_act_r <= ld_act_nxt;
            ld_pend_r <= ld_pend_nxt;
            ld_cnt_r <= ld_cnt_nxt;
            xcnt_r <= xcnt_nxt;
            scan_r <= scan_nxt;
            smax_r <= smax_nxt;
            scan_v_r <= scan_v_nxt;
            drd_v_r <= drd_v_nxt;
            lane_r <= lane_nxt;
            shift_r <= shift_nxt;
            j_r <= j_nxt;
            s_r <= s_nxt;
            l_r <= l_nxt;
            p_r <= p_nxt;
            prime_r <= prime_nxt;
            results_ready_flag <= dav_nxt;
            load_progress_flag <= load_progress_flag_nxt;
            result_oe_n <= oe_n_nxt;
            data_re_out <= dre_nxt;
            data_im_out <= dim_nxt;
            scale_out <= shift_nxt;
        end
    end

    // ==========================================================================
    // Checks
    logic [12:0] age_r;
    always_ff @(posedge ref_clk) begin
        if (!rst_n || st_r != ST_XFORM) begin
            age_r <= 13'd0;
        end else begin
            age_r <= age_r + 13'd1;
        end
    end
    sequence load_done_s;
        ld_done && st_r == ST_IDLE && !def_s;
    endsequence
    sequence xform_s;
        st_r == ST_XFORM [*2];
    endsequence
    a_auto_start: assert property (@(posedge ref_clk) disable iff (!rst_n) load_done_s |=> xform_s)
        else $error("transform did not start after a full load");
    a_complex_budget: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r == ST_XFORM && !rmode) |-> age_r < p_lim) else $error("complex transform overran its budget");
    a_real_budget: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r == ST_XFORM && rmode) |-> age_r < p_lim) else $error("real transform overran its budget");
    a_oe_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !result_oe_n |-> results_ready_flag && $past(ren_s)) else $error("outputs driven without flag and enable");
    a_big_no_overlap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (big && st_r != ST_IDLE) |-> !ram.we_re && !ram.we_im) else $error("1024 mode load during transform or dump");
    a_first_half: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rmode && st_r == ST_DUMP) |-> j_r < (sb_w >> 1)) else $error("real dump past the first half of the bins");
    a_single_lane: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (single_src && ram.we_im) |-> !ram.we_re && ram.wdata_im == din_re) else $error("single source used imag input");
    // lane A finishes before lane B
    a_lane_order: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r == ST_DUMP && $rose(l_r)) |-> $past(j_r) == lim_j - 16'h0001) else $error("lane B started early");
    a_joint_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(results_ready_flag) |-> scale_out == headroom($past(smax_r))) else $error("shift not from joint peak");
endmodule

// ---- verilog/sample_ram.sv ----
// Two-lane sample memory with one write port and one registered read port.
`timescale 1ns/10ps
module sample_ram #(
    parameter int DW = 16,
    parameter int AW = 10
) (
    input wire logic ref_clk,
    ram_if.ram bus
);
    logic [DW-1:0] lane_re [2**AW];
    logic [DW-1:0] lane_im [2**AW];
    logic [2*DW-1:0] rdata_r;

    // ==========================================================================
    // Storage
    always_ff @(posedge ref_clk) begin
        if (bus.we_re) begin
            lane_re[bus.waddr] <= bus.wdata_re;
        end
        if (bus.we_im) begin
            lane_im[bus.waddr] <= bus.wdata_im;
        end
        rdata_r <= {lane_re[bus.raddr], lane_im[bus.raddr]};
    end

    assign bus.rdata = rdata_r;
endmodule
